// ==== head_link_pkg.sv ====
// constants, map tables and state codes shared by both ends of the head link
// Operation
// - decode block code into six exclusive selects
// - reverse strap high issues blocks six to one
// - shift serial bits into 310 or 240 register
// - latch strobe captures register, holds until next
// - fire only with block select and parity gate
// - set gated bit pulls heater node low
// - blocks map to fixed nozzle groups
// - controller sends reversed order to mirrored heads
// - 310 heads: odd gate odd, mirrored opposite
// - 240 heads: parity gating by enable wiring
// - two index pins, open or pulled down
// - controller pulls up, low means pulled down
// - unknown index code disables printing, flags error
// - ink pulses on shared pins outside index sampling
// - controller supplies shift clock with data
// - controller drives three block code lines
`default_nettype none
package head_link_pkg;
  // ==========================================================
  // head geometry
  localparam int NOZ_WIDE   = 310;
  localparam int NOZ_NARROW = 240;
  localparam int BLOCKS     = 6;
  localparam int MAP_ENTRIES = 18;
  localparam logic [8:0] LEN_WIDE   = 9'h136;
  localparam logic [8:0] LEN_NARROW = 9'h0f0;
  localparam logic [2:0] CODE_NONE  = 3'h7;
  // last nozzle of each block, three groups of six, low to high
  localparam int UP_WIDE [MAP_ENTRIES] = '{7, 25, 43, 61, 79, 99,
    119, 137, 155, 173, 191, 211, 231, 249, 267, 285, 303, 310};
  localparam int UP_NARROW [MAP_ENTRIES] = '{0, 6, 24, 42, 60, 80,
    84, 102, 120, 138, 156, 160, 180, 198, 216, 234, 240, 240};
  // ==========================================================
  // register map of the controller
  localparam int LINE_WORDS = 10;
  localparam logic [7:0] A_CTRL     = 8'h00;
  localparam logic [7:0] A_STATUS   = 8'h04;
  localparam logic [7:0] A_LINE0    = 8'h40;
  localparam logic [7:0] A_LINE_END = 8'h68;
  localparam int CTRL_W = 7;
  localparam int C_START = 0;
  localparam int C_WIDE  = 1;
  localparam int C_REV   = 2;
  localparam int C_ODD   = 3;
  localparam int C_EVEN  = 4;
  localparam int C_INK   = 5;
  localparam int C_SCAN  = 6;
  localparam int S_BUSY  = 0;
  localparam int S_ERR   = 1;
  localparam int S_ID1   = 2;
  localparam int S_ID2   = 3;
  localparam int S_VALID = 4;
  // ==========================================================
  // link timing in link clock periods, bus codes
  localparam logic [3:0] HEAT_TICKS   = 4'h4;
  localparam logic [3:0] SETTLE_TICKS = 4'h8;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;
  localparam logic       HRESP_OKAY    = 1'b0;
  typedef enum logic [4:0] {
    ST_SCAN  = 5'h01,
    ST_IDLE  = 5'h02,
    ST_SHIFT = 5'h04,
    ST_LATCH = 5'h08,
    ST_HEAT  = 5'h10
  } ctl_state_e;
  // block of a nozzle (1-based); lowest matching bound wins
  function automatic int block_of(input int n, input bit wide);
    int r;
    r = 0;
    for (int k = MAP_ENTRIES - 1; k >= 0; k--) begin
      if (n <= (wide ? UP_WIDE[k] : UP_NARROW[k])) begin
        r = k % BLOCKS;
      end
    end
    return r;
  endfunction
endpackage
`default_nettype wire

// ==== head_link_if.sv ====
// link between the printer controller and one print head
`timescale 1ns/10ps
`default_nettype none
interface head_link_if;
  // clocked serial path, made by the controller
  logic shift_bit_clock;
  logic head_reset_n;
  logic serial_print_bits;
  logic line_latch_strobe;
  logic block_code_bit0;
  logic block_code_bit1;
  logic block_code_bit2;
  logic odd_heat_gate;
  logic even_heat_gate;
  // index pins; on colour heads they are the shared ink pins
  logic head_one_oe_n;
  logic head_two_oe_n;
  logic host_one_out;
  logic host_one_oe_n;
  logic host_two_out;
  logic host_two_oe_n;
  logic type_pin_one;
  logic type_pin_two;
  // strong controller drive beats the head resistor, else pull-up
  assign type_pin_one = !host_one_oe_n ? host_one_out :
                        (!head_one_oe_n ? 1'b0 : 1'b1);
  assign type_pin_two = !host_two_oe_n ? host_two_out :
                        (!head_two_oe_n ? 1'b0 : 1'b1);
  modport head (
    input  shift_bit_clock, head_reset_n, serial_print_bits,
    input  line_latch_strobe, block_code_bit0, block_code_bit1,
    input  block_code_bit2, odd_heat_gate, even_heat_gate,
    output head_one_oe_n, head_two_oe_n
  );
  modport ctrl (
    output shift_bit_clock, head_reset_n, serial_print_bits,
    output line_latch_strobe, block_code_bit0, block_code_bit1,
    output block_code_bit2, odd_heat_gate, even_heat_gate,
    output host_one_out, host_one_oe_n, host_two_out, host_two_oe_n,
    input  type_pin_one, type_pin_two
  );
endinterface
`default_nettype wire

// ==== level_sync.sv ====
// two flip-flop level synchroniser
`timescale 1ns/10ps
`default_nettype none
module level_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset of the receiving domain
  input  wire logic             clk,
  input  wire logic             rst_n,
  // level in, level out
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] q;
  } sync_s;
  sync_s cur_ff;
  sync_s nxt_ff;
  // first stage feeds only the second stage
  always_comb begin
    nxt_ff      = cur_ff;
    nxt_ff.meta = d;
    nxt_ff.q    = cur_ff.meta;
  end
  // ==========================================================
  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end
  assign q = cur_ff.q;
endmodule // level_sync
`default_nettype wire

// ==== head_drive.sv ====
// heater board drive logic of one print head, clocked by the link clock
`timescale 1ns/10ps
`default_nettype none
module head_drive #(
  // 1: 310-nozzle head, 0: 240-nozzle head
  parameter bit WIDE     = 1'b1,
  // index resistor fitted on pin one / pin two
  parameter bit ONE_DOWN = 1'b0,
  parameter bit TWO_DOWN = 1'b1
) (
  // link to the controller
  head_link_if.head                          link,
  // order strap tied by the cartridge wiring
  input  wire logic                          order_reverse_strap,
  // open-drain heater nodes, low enable pulls the node low
  output logic [head_link_pkg::NOZ_WIDE-1:0] heater_oe_n
);
  localparam int W = WIDE ? head_link_pkg::NOZ_WIDE : head_link_pkg::NOZ_NARROW;
  localparam int NW = head_link_pkg::NOZ_WIDE;
  localparam int NB = head_link_pkg::BLOCKS;

  // ==========================================================
  // state
  typedef struct packed {
    logic [NW-1:0] shift;
    logic [NW-1:0] latch;
    logic [NB-1:0] sel;
    logic [NW-1:0] heat_oe_n;
    logic          one_oe_n;
    logic          two_oe_n;
  } head_s;

  head_s cur_ff;
  head_s nxt_ff;
  logic          rev;
  logic [2:0]    code;
  logic [NW-1:0] fire;
  logic [2:0]    blk_idx;

  // ==========================================================
  // strap crossing
  // the strap is a pin outside the link timing, so it is synchronised
  // even though it is static in a real cartridge
  level_sync #(
    .WIDTH (1)
  ) u_strap_sync (
    .clk   (link.shift_bit_clock),
    .rst_n (link.head_reset_n),
    .d     (order_reverse_strap),
    .q     (rev)
  );

  assign code = {link.block_code_bit2, link.block_code_bit1,
                 link.block_code_bit0};

  // mirrored heads count the blocks from the other end
  always_comb begin
    blk_idx = code;
    if (rev) begin
      blk_idx = 3'(NB - 1) - code;
    end
  end

  // ==========================================================
  // per-nozzle gate
  // bit i holds nozzle W-i: the first bit shifted in lands on nozzle 1
  // the block and parity of each bit are fixed wiring, resolved here
  // at elaboration rather than by a run-time lookup
  for (genvar i = 0; i < NW; i++) begin : g_noz
    localparam int N = W - i;
    if (i < W) begin : g_on
      localparam int B = head_link_pkg::block_of(N, WIDE);
      localparam bit ODD = (N % 2) == 1;
      // odd gate serves odd nozzles, or even ones on a mirrored head
      assign fire[i] = cur_ff.latch[i] & cur_ff.sel[B] &
                       ((ODD ^ rev) ? link.odd_heat_gate
                                    : link.even_heat_gate);
    end else begin : g_off
      // bits beyond a narrow head have no heater
      assign fire[i] = 1'b0;
    end
  end

  // ==========================================================
  // next state
  always_comb begin
    nxt_ff = cur_ff;
    // one bit per rising link clock edge, no enable
    nxt_ff.shift = {cur_ff.shift[NW-2:0], link.serial_print_bits};
    // strobe copies the whole register; latch holds otherwise
    if (link.line_latch_strobe) begin
      nxt_ff.latch = cur_ff.shift;
    end
    // one select per valid code, none for codes six and seven
    if (code < 3'(NB)) begin
      nxt_ff.sel = NB'(1) << blk_idx;
    end else begin
      nxt_ff.sel = '0;
    end
    // a set, gated bit pulls its heater node low
    nxt_ff.heat_oe_n = ~fire;
    // index resistors present their fixed pattern
    nxt_ff.one_oe_n = !ONE_DOWN;
    // the resistor is weak, so a controller ink pulse on a shared
    // pin simply overrides it
    nxt_ff.two_oe_n = !TWO_DOWN;
  end

  // ==========================================================
  // state register
  // reset leaves every heater off and every index pin released
  always_ff @(posedge link.shift_bit_clock or negedge link.head_reset_n) begin
    if (!link.head_reset_n) begin
      cur_ff           <= '0;
      cur_ff.heat_oe_n <= '1;
      cur_ff.one_oe_n  <= 1'b1;
      cur_ff.two_oe_n  <= 1'b1;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // ==========================================================
  // outputs
  assign heater_oe_n        = cur_ff.heat_oe_n;
  assign link.head_one_oe_n = cur_ff.one_oe_n;
  assign link.head_two_oe_n = cur_ff.two_oe_n;
endmodule // head_drive
`default_nettype wire

// ==== head_controller.sv ====
// printer-side head controller with an AHB-Lite register slave
`timescale 1ns/10ps
`default_nettype none
module head_controller (
  // bus clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // link to the head
  head_link_if.ctrl        link
);
  localparam int LW = head_link_pkg::LINE_WORDS;

  // ==========================================================
  // state
  typedef struct packed {
    head_link_pkg::ctl_state_e state;
    logic                      lclk;
    logic                      rst_o;
    logic                      data;
    logic                      strobe;
    logic [2:0]                code;
    logic                      odd;
    logic                      even;
    logic                      pin_out;
    logic                      pin_oe_n;
    logic [8:0]                bitcnt;
    logic [2:0]                blk;
    logic [3:0]                cnt;
    logic [head_link_pkg::CTRL_W-1:0] cfg;
    logic                      go;
    logic                      scan;
    logic [1:0]                idx;
    logic                      err;
    logic                      valid;
    logic [7:0]                addr;
    logic                      wr_pend;
    logic                      rd_pend;
    logic                      ready;
    logic                      resp;
    logic [31:0]               rdata;
    logic [LW-1:0][31:0]       line;
  } ctl_s;

  ctl_s cur_ff;
  ctl_s nxt_ff;
  logic [1:0]    pins;
  logic [LW*32-1:0] line_flat;
  logic [8:0]    w_len;
  logic [8:0]    pick;
  logic [7:0]    off;
  logic          accept;
  logic          tick;
  logic [31:0]   rd_mux;
  logic          start_wr;
  logic          scan_wr;

  // index pins come from another board, so they are synchronised
  level_sync #(
    .WIDTH (2)
  ) u_pin_sync (
    .clk   (hclk),
    .rst_n (hresetn),
    .d     ({link.type_pin_two, link.type_pin_one}),
    .q     (pins)
  );

  assign line_flat = cur_ff.line;
  assign w_len  = cur_ff.cfg[head_link_pkg::C_WIDE] ? head_link_pkg::LEN_WIDE
                                                    : head_link_pkg::LEN_NARROW;
  // mirrored heads get the image back to front
  assign pick   = cur_ff.cfg[head_link_pkg::C_REV] ?
                  w_len - 9'h001 - cur_ff.bitcnt : cur_ff.bitcnt;
  assign off    = cur_ff.addr - head_link_pkg::A_LINE0;
  assign accept = hsel && hready && (htrans == head_link_pkg::HTRANS_NONSEQ) &&
                  (hsize == head_link_pkg::HSIZE_WORD);
  // link outputs change as the divided clock falls
  assign tick   = cur_ff.lclk;
  // a command landing as the sequencer consumes the last one is kept
  assign start_wr = cur_ff.wr_pend && (cur_ff.addr == head_link_pkg::A_CTRL) &&
                    hwdata[head_link_pkg::C_START];
  assign scan_wr  = cur_ff.wr_pend && (cur_ff.addr == head_link_pkg::A_CTRL) &&
                    hwdata[head_link_pkg::C_SCAN];

  // ==========================================================
  // read multiplexer, unmapped words read zero
  always_comb begin
    rd_mux = '0;
    if (cur_ff.addr == head_link_pkg::A_CTRL) begin
      rd_mux[head_link_pkg::CTRL_W-1:0] = cur_ff.cfg;
    end else if (cur_ff.addr == head_link_pkg::A_STATUS) begin
      rd_mux[head_link_pkg::S_BUSY]  = cur_ff.go ||
        !(cur_ff.state inside {head_link_pkg::ST_IDLE, head_link_pkg::ST_SCAN});
      rd_mux[head_link_pkg::S_ERR]   = cur_ff.err;
      rd_mux[head_link_pkg::S_ID1]   = cur_ff.idx[0];
      rd_mux[head_link_pkg::S_ID2]   = cur_ff.idx[1];
      rd_mux[head_link_pkg::S_VALID] = cur_ff.valid;
    end else if (cur_ff.addr >= head_link_pkg::A_LINE0 &&
                 cur_ff.addr < head_link_pkg::A_LINE_END) begin
      rd_mux = cur_ff.line[off[5:2]];
    end
  end

  // ==========================================================
  // next state
  always_comb begin
    nxt_ff       = cur_ff;
    // divide by two: the link clock runs free from reset release
    nxt_ff.lclk  = !cur_ff.lclk;
    // head reset lifts on a falling link edge, clear of its sampling edge
    nxt_ff.rst_o = cur_ff.rst_o || cur_ff.lclk;
    // bus: writes take no wait, reads take one
    nxt_ff.wr_pend = accept && hwrite;
    if (cur_ff.rd_pend) begin
      nxt_ff.rdata   = rd_mux;
      nxt_ff.ready   = 1'b1;
      nxt_ff.rd_pend = 1'b0;
    end
    if (accept) begin
      nxt_ff.addr = haddr[7:0];
      if (!hwrite) begin
        nxt_ff.rd_pend = 1'b1;
        nxt_ff.ready   = 1'b0;
      end
    end
    if (cur_ff.wr_pend) begin
      if (cur_ff.addr == head_link_pkg::A_CTRL) begin
        nxt_ff.cfg = hwdata[head_link_pkg::CTRL_W-1:0];
        nxt_ff.cfg[head_link_pkg::C_START] = 1'b0;
        nxt_ff.cfg[head_link_pkg::C_SCAN]  = 1'b0;
        nxt_ff.go   = cur_ff.go || hwdata[head_link_pkg::C_START];
        nxt_ff.scan = cur_ff.scan || hwdata[head_link_pkg::C_SCAN];
      end else if (cur_ff.addr >= head_link_pkg::A_LINE0 &&
                   cur_ff.addr < head_link_pkg::A_LINE_END) begin
        nxt_ff.line[off[5:2]] = hwdata;
      end
    end
    // link sequencer, one step per link clock period
    if (tick) begin
      // ink pulses only while index sampling is not running
      if (cur_ff.state != head_link_pkg::ST_SCAN &&
          cur_ff.cfg[head_link_pkg::C_INK]) begin
        nxt_ff.pin_oe_n = 1'b0;
        nxt_ff.pin_out  = !cur_ff.pin_out;
      end else begin
        nxt_ff.pin_oe_n = 1'b1;
        nxt_ff.pin_out  = 1'b0;
      end
      case (cur_ff.state)
        head_link_pkg::ST_SCAN: begin
          nxt_ff.cnt = cur_ff.cnt + 4'h1;
          if (cur_ff.cnt == head_link_pkg::SETTLE_TICKS) begin
            // low reads as resistor fitted, high as open
            nxt_ff.idx   = pins;
            // any code with pin two pulled down is a known head; pin one is ignored
            nxt_ff.err   = pins[1];
            nxt_ff.valid = 1'b1;
            nxt_ff.cnt   = '0;
            nxt_ff.state = head_link_pkg::ST_IDLE;
          end
        end
        head_link_pkg::ST_IDLE: begin
          if (cur_ff.scan) begin
            nxt_ff.scan  = scan_wr;
            nxt_ff.state = head_link_pkg::ST_SCAN;
          end else if (cur_ff.go) begin
            // a start with a bad cartridge is dropped
            nxt_ff.go = start_wr;
            if (!cur_ff.err) begin
              nxt_ff.bitcnt = '0;
              nxt_ff.state  = head_link_pkg::ST_SHIFT;
            end
          end
        end
        head_link_pkg::ST_SHIFT: begin
          nxt_ff.data   = line_flat[pick];
          nxt_ff.bitcnt = cur_ff.bitcnt + 9'h001;
          if (cur_ff.bitcnt == w_len - 9'h001) begin
            nxt_ff.state = head_link_pkg::ST_LATCH;
          end
        end
        head_link_pkg::ST_LATCH: begin
          // the whole line is in before the strobe
          nxt_ff.strobe = 1'b1;
          nxt_ff.blk    = '0;
          nxt_ff.cnt    = '0;
          nxt_ff.state  = head_link_pkg::ST_HEAT;
        end
        head_link_pkg::ST_HEAT: begin
          nxt_ff.strobe = 1'b0;
          // gates drop whenever the code moves, since the head's
          // select lags the code by one link edge
          if (cur_ff.cnt == 4'h0) begin
            nxt_ff.code = cur_ff.blk;
            nxt_ff.cnt  = 4'h1;
          end else if (cur_ff.cnt <= head_link_pkg::HEAT_TICKS) begin
            nxt_ff.odd  = cur_ff.cfg[head_link_pkg::C_ODD];
            nxt_ff.even = cur_ff.cfg[head_link_pkg::C_EVEN];
            nxt_ff.cnt  = cur_ff.cnt + 4'h1;
          end else begin
            nxt_ff.odd  = 1'b0;
            nxt_ff.even = 1'b0;
            nxt_ff.cnt  = 4'h1;
            if (cur_ff.blk == 3'(head_link_pkg::BLOCKS - 1)) begin
              nxt_ff.code  = head_link_pkg::CODE_NONE;
              nxt_ff.state = head_link_pkg::ST_IDLE;
            end else begin
              nxt_ff.blk  = cur_ff.blk + 3'h1;
              nxt_ff.code = cur_ff.blk + 3'h1;
            end
          end
        end
        default: begin
          nxt_ff.state = head_link_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur_ff          <= '0;
      cur_ff.state    <= head_link_pkg::ST_SCAN;
      cur_ff.code     <= head_link_pkg::CODE_NONE;
      cur_ff.pin_oe_n <= 1'b1;
      cur_ff.ready    <= 1'b1;
      cur_ff.resp     <= head_link_pkg::HRESP_OKAY;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // ==========================================================
  // outputs
  assign hreadyout              = cur_ff.ready;
  assign hresp                  = cur_ff.resp;
  assign hrdata                 = cur_ff.rdata;
  assign link.shift_bit_clock   = cur_ff.lclk;
  assign link.head_reset_n      = cur_ff.rst_o;
  assign link.serial_print_bits = cur_ff.data;
  assign link.line_latch_strobe = cur_ff.strobe;
  assign link.block_code_bit0   = cur_ff.code[0];
  assign link.block_code_bit1   = cur_ff.code[1];
  assign link.block_code_bit2   = cur_ff.code[2];
  assign link.odd_heat_gate     = cur_ff.odd;
  assign link.even_heat_gate    = cur_ff.even;
  assign link.host_one_out      = cur_ff.pin_out;
  assign link.host_one_oe_n     = cur_ff.pin_oe_n;
  assign link.host_two_out      = cur_ff.pin_out;
  assign link.host_two_oe_n     = cur_ff.pin_oe_n;
endmodule // head_controller
`default_nettype wire

// ==== head_link_assertions.sv ====
// concurrent checks on the link between the head controller and the print head
`timescale 1ns/10ps
`default_nettype none
module head_link_assertions #(
  parameter bit TWO_DOWN = 1'b1
) (
  // link clock and head reset
  input wire logic shift_bit_clock,
  input wire logic head_reset_n,
  // controls sampled by the head
  input wire logic line_latch_strobe,
  input wire logic block_code_bit0,
  input wire logic block_code_bit1,
  input wire logic block_code_bit2,
  input wire logic odd_heat_gate,
  input wire logic even_heat_gate,
  // shared index pins
  input wire logic host_one_oe_n,
  input wire logic host_one_out,
  input wire logic host_two_oe_n,
  input wire logic type_pin_two
);
  // ==========================================================
  // helpers; the head samples everything at the rising link clock
  wire logic [2:0] code = {block_code_bit2, block_code_bit1, block_code_bit0};
  wire logic       heat = odd_heat_gate | even_heat_gate;
  default clocking cb @(posedge shift_bit_clock); endclocking
  default disable iff (!head_reset_n);
  // ==========================================================
  // assertions
  a_strobe_one_tick: assert property (line_latch_strobe |=> !line_latch_strobe)
    else $error("latch strobe held longer than one tick");
  a_no_heat_latch: assert property (line_latch_strobe |-> !heat)
    else $error("heat gate high during latch strobe");
  a_code_in_range: assert property (code != 3'h6)
    else $error("block code six driven");
  a_heat_width: assert property ($rose(heat) |-> heat [*4] ##1 !heat)
    else $error("heat pulse not four ticks");
  a_code_while_cold: assert property ($changed(code) |-> !heat)
    else $error("block code changed while heating");
  a_first_block: assert property ($fell(line_latch_strobe) |-> code == 3'h0)
    else $error("first block after latch is not code zero");
  a_scan_quiet: assert property ($rose(head_reset_n) |-> host_one_oe_n [*8])
    else $error("ink pulse driven during index scan");
  a_index_level: assert property (
      host_two_oe_n && $past(host_two_oe_n, 2)
      && $past(head_reset_n, 3) |-> type_pin_two == !TWO_DOWN)
    else $error("index pin two level wrong");
  a_ink_toggles: assert property (
      !host_one_oe_n && !$past(host_one_oe_n)
      |-> host_one_out != $past(host_one_out))
    else $error("ink pulse did not toggle");
  // main scenarios seen
  c_latch: cover property ($fell(line_latch_strobe));
  c_heat: cover property ($rose(heat));
  c_ink: cover property (!host_one_oe_n);
endmodule // head_link_assertions
`default_nettype wire

// ==== testbench.sv ====
// self-checking bench: controller and print head joined over the link
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin error_cnt++; \
  $display("unexpected %s: expected %0h seen %0h", nm, exp, got); end end
module testbench;
  // ==========================================================
  // clock, reset, bus and strap
  logic         hclk;
  logic         hresetn;
  logic [31:0]  haddr;
  logic [1:0]   htrans;
  logic         hwrite;
  logic [31:0]  hwdata;
  logic         hreadyout;
  logic [31:0]  hrdata;
  logic         strap;
  logic [309:0] heater_oe_n;
  logic [31:0]  line_w [10];
  int           error_cnt;
  int           n_checks;
  int           cycles;
  head_link_if lk ();
  head_controller u_head_controller (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(head_link_pkg::HSIZE_WORD),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata),
    .link(lk));
  head_drive #(.WIDE(1'b1), .ONE_DOWN(1'b0), .TWO_DOWN(1'b1)) u_head_drive (.link(lk),
    .order_reverse_strap(strap), .heater_oe_n(heater_oe_n));
  head_link_assertions #(.TWO_DOWN(1'b1)) u_head_link_assertions (
    .shift_bit_clock(lk.shift_bit_clock), .head_reset_n(lk.head_reset_n),
    .line_latch_strobe(lk.line_latch_strobe), .block_code_bit0(lk.block_code_bit0),
    .block_code_bit1(lk.block_code_bit1), .block_code_bit2(lk.block_code_bit2),
    .odd_heat_gate(lk.odd_heat_gate), .even_heat_gate(lk.even_heat_gate),
    .host_one_oe_n(lk.host_one_oe_n), .host_one_out(lk.host_one_out),
    .host_two_oe_n(lk.host_two_oe_n), .type_pin_two(lk.type_pin_two));
  // ==========================================================
  // clock and hang guard; a print line takes about 700 cycles
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    if (error_cnt == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ==========================================================
  // single word transfer; ready is sampled before the edge updates land
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    haddr  <= {24'h000000, a};
    htrans <= head_link_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  // ==========================================================
  // scenarios
  task automatic index_scan();
    logic [31:0] v;
    int          k;
    k = 0;
    wr(head_link_pkg::A_CTRL, 32'h00000040);
    do begin
      bus(1'b0, head_link_pkg::A_STATUS, 32'h0, v);
      k++;
    end while (v[4] !== 1'b1 && k < 40);
    `CHK("status", 32'h00000014, v)
  endtask
  task automatic regs_and_ink();
    logic [31:0] v;
    logic        p;
    int          tog;
    tog = 0;
    wr(8'h80, 32'hffffffff);
    bus(1'b0, 8'h80, 32'h0, v);
    `CHK("unmapped", 32'h00000000, v)
    wr(head_link_pkg::A_CTRL, 32'h00000022);
    bus(1'b0, head_link_pkg::A_CTRL, 32'h0, v);
    `CHK("ctrl", 32'h00000022, v)
    p = lk.type_pin_one;
    repeat (40) begin
      @(posedge hclk);
      if (lk.type_pin_one !== p) tog++;
      p = lk.type_pin_one;
    end
    `CHK("ink pulses", 1'b1, tog > 10)
    wr(head_link_pkg::A_CTRL, 32'h00000000);
  endtask
  // one line printed; checks the first block fired and the whole fired set
  task automatic run_print(input logic st, input logic rev, input logic odd);
    logic [309:0] fired;
    logic [309:0] first;
    logic [309:0] e_all;
    logic [309:0] e_first;
    logic         b;
    int           m;
    int           k;
    strap <= st;
    for (k = 0; k < 10; k++) begin
      line_w[k] = 32'hc3a50f69 ^ (32'(k) * 32'h13579bdf);
      wr(head_link_pkg::A_LINE0 + 8'(4 * k), line_w[k]);
    end
    for (int n = 1; n <= 310; n++) begin
      m = rev ? 311 - n : n;
      b = line_w[(m - 1) / 32][(m - 1) % 32] && ((n % 2 == 1) == (odd ^ st));
      e_all[310 - n] = b;
      e_first[310 - n] = b && (st ? (n >= 304 || (n >= 80 && n <= 99) || (n >= 192 && n <= 211))
                         : (n <= 7 || (n >= 100 && n <= 119) || (n >= 212 && n <= 231)));
    end
    wr(head_link_pkg::A_CTRL, {27'h0, !odd, odd, rev, 2'h3});
    fired = '0;
    first = '0;
    for (k = 0; k < 3000; k++) begin
      @(posedge hclk);
      if (first == '0) first = ~heater_oe_n;
      fired = fired | ~heater_oe_n;
      if (first != '0 && heater_oe_n == '1 && lk.block_code_bit2 === 1'b1
          && lk.block_code_bit1 === 1'b1 && lk.block_code_bit0 === 1'b1) break;
    end
    `CHK("first block", e_first, first)
    `CHK("fired set", e_all, fired)
    `CHK("heaters idle", {310{1'b1}}, heater_oe_n)
  endtask
  // ==========================================================
  // main sequence
  initial begin
    hresetn = 1'b0;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = '0;
    strap = 1'b0;
    error_cnt = 0;
    n_checks = 0;
    cycles = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    index_scan();
    regs_and_ink();
    run_print(1'b0, 1'b0, 1'b1);
    run_print(1'b1, 1'b1, 1'b1);
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
